// ### src/dstc_pkg.sv
package dstc_pkg;
  localparam int          REG_AW          = 4;
  localparam logic [3:0]  MEMCTL_OFFSET   = 4'h0;
  localparam logic [3:0]  STATUS_OFFSET   = 4'h4;
  localparam logic [31:0] MEMCTL_RESET    = 32'h00000000;
  localparam logic [31:0] MEMCTL_WMASK    = 32'hf8bbffff;
  localparam int          ROW_OPEN_BIT    = 31;
  localparam int          INIT_CMD_BIT    = 30;
  localparam int          TRC_LSB         = 27;
  localparam int          CAS_NEG_BIT     = 23;
  localparam int          TPC_LSB         = 19;
  localparam int          RCD_LSB         = 16;
  localparam int          TRWL_LSB        = 13;
  localparam int          TRAS_LSB        = 10;
  localparam int          CNT_W           = 6;
  localparam logic [5:0]  TRAS_DRAM_BASE  = 6'h02;
  localparam logic [5:0]  TRAS_SDRAM_BASE = 6'h04;
  localparam logic [5:0]  RCD_DRAM_BASE   = 6'h02;
  localparam logic [5:0]  RCD_SDRAM_BASE  = 6'h01;
  typedef enum logic [2:0] {
    DSTC_IDLE, DSTC_ACTIVE, DSTC_WRITE, DSTC_REFRESH, DSTC_PRECHARGE
  } dstc_evt_t;
endpackage

// ### src/dstc_gap_counter.sv
`timescale 1ns/1ps
module dstc_gap_counter
  import dstc_pkg::*;
#(
  parameter int W = dstc_pkg::CNT_W
)(
  input  wire logic         clk_i,    // clock
  input  wire logic         rstn_i,   // sync reset, active low
  input  wire logic         load_i,   // start hold-off
  input  wire logic [W-1:0] count_i,  // cycles to hold
  output logic              busy_o    // hold-off running
);
  if (W < 6)
  begin
    $error("counter width too small");
  end
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  always_comb
  begin
    cnt_nxt = cnt_r;
    if (load_i)
      cnt_nxt = count_i;
    else if (cnt_r != '0)
      cnt_nxt = cnt_r - 1'b1;
  end
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      cnt_r <= '0;
    else
      cnt_r <= cnt_nxt;
  end
  assign busy_o = (cnt_r != '0);
endmodule

// ### src/dstc_timing_decode.sv
`timescale 1ns/1ps
module dstc_timing_decode
  import dstc_pkg::*;
(
  input  wire logic [31:0] cfg_i,       // memory_control value
  input  wire logic        sdram_i,     // sdram interface chosen
  output logic [5:0]       refr_end_o,  // precharge after refresh
  output logic [5:0]       cas_neg_o,   // cas negation cycles
  output logic [5:0]       prech_o,     // precharge period
  output logic [5:0]       rcd_o,       // row to column delay
  output logic [5:0]       wpd_o,       // write precharge delay
  output logic [5:0]       ras_ref_o    // refresh row assert
);
  function automatic logic [5:0] fld3(input logic [31:0] v, input int lsb);
    fld3 = {3'h0, v[lsb +: 3]};
  endfunction
  always_comb
  begin
    refr_end_o = 6'(fld3(cfg_i, TRC_LSB) * 3);
    cas_neg_o  = cfg_i[CAS_NEG_BIT] ? 6'h02 : 6'h01;
    prech_o    = fld3(cfg_i, TPC_LSB) + (sdram_i ? 6'h01 : 6'h00);
    rcd_o      = {4'h0, cfg_i[RCD_LSB +: 2]}
                 + (sdram_i ? RCD_SDRAM_BASE : RCD_DRAM_BASE);
    wpd_o      = sdram_i ? fld3(cfg_i, TRWL_LSB) + 6'h01 : 6'h00;
    ras_ref_o  = fld3(cfg_i, TRAS_LSB)
                 + (sdram_i ? TRAS_SDRAM_BASE : TRAS_DRAM_BASE);
  end
endmodule

// ### src/dstc_top.sv
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module dstc_top
  import dstc_pkg::*;
(
  input  wire logic                        MCLK_I,       // bus clock
  input  wire logic                        RSTN_I,       // power-on reset
  input  wire logic [dstc_pkg::REG_AW-1:0] ADDR_I,       // register address
  input  wire logic [31:0]                 WDATA_I,      // write data
  input  wire logic                        WR_I,         // write strobe
  input  wire logic                        RD_I,         // read strobe
  input  wire logic                        SDRAM_SEL_I,  // sdram interface
  input  wire logic                        EVT_ACT_I,    // bank active done
  input  wire logic                        EVT_WR_I,     // write cycle done
  input  wire logic                        EVT_REF_I,    // refresh done
  input  wire logic                        EVT_PRE_I,    // precharge done
  output logic [31:0]                      RDATA_O,      // read data
  output logic                             ROW_OPEN_O,   // row open mode
  output logic                             INIT_MRS_O,   // init command
  output logic [5:0]                       CAS_NEG_O,    // cas negate cyc
  output logic [5:0]                       RCD_O,        // ras-cas cycles
  output logic                             ACT_HOLD_O,   // block active
  output logic                             PRE_HOLD_O    // block precharge
);
  import dstc_pkg::*;

  logic [31:0] memctl_r;
  logic [31:0] memctl_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic        row_open_r;
  logic        init_mrs_r;
  logic [5:0]  cas_neg_r;
  logic [5:0]  rcd_r;
  logic        act_hold_r;
  logic        pre_hold_r;
  logic [5:0]  refr_end;
  logic [5:0]  cas_neg;
  logic [5:0]  prech;
  logic [5:0]  rcd;
  logic [5:0]  wpd;
  logic [5:0]  ras_ref;
  logic        act_load;
  logic [5:0]  act_count;
  logic        pre_load;
  logic [5:0]  pre_count;
  logic        act_busy;
  logic        pre_busy;
  logic [5:0]  status;

  // register file, reset only by power-on reset
  always_comb
  begin
    memctl_nxt = memctl_r;
    if (WR_I && ADDR_I == MEMCTL_OFFSET)
      memctl_nxt = WDATA_I & MEMCTL_WMASK;
  end

  always_comb
  begin
    rdata_nxt = 32'h00000000;
    if (RD_I)
    begin
      case (ADDR_I)
        MEMCTL_OFFSET: rdata_nxt = memctl_r;
        STATUS_OFFSET: rdata_nxt = {26'h0, status};
        default:       rdata_nxt = 32'h00000000;
      endcase
    end
  end

  assign status = {4'h0, pre_busy, act_busy};

  dstc_timing_decode u_dec (
    .cfg_i      (memctl_r),
    .sdram_i    (SDRAM_SEL_I),
    .refr_end_o (refr_end),
    .cas_neg_o  (cas_neg),
    .prech_o    (prech),
    .rcd_o      (rcd),
    .wpd_o      (wpd),
    .ras_ref_o  (ras_ref)
  );

  // hold-off load selection; for the active hold refresh wins over write, write over precharge
  always_comb
  begin
    act_load  = 1'b0;
    act_count = 6'h00;
    pre_load  = 1'b0;
    pre_count = 6'h00;
    if (EVT_REF_I)
    begin
      act_load  = 1'b1;
      act_count = SDRAM_SEL_I ? 6'(ras_ref + refr_end) : refr_end;
    end
    else if (EVT_WR_I && SDRAM_SEL_I && !memctl_r[ROW_OPEN_BIT])
    begin
      act_load  = 1'b1;
      act_count = 6'(prech + wpd);
    end
    else if (EVT_PRE_I)
    begin
      act_load  = 1'b1;
      act_count = prech;
    end
    if (EVT_WR_I && SDRAM_SEL_I && memctl_r[ROW_OPEN_BIT])
    begin
      pre_load  = 1'b1;
      pre_count = wpd;
    end
  end

  dstc_gap_counter #(.W(CNT_W)) u_act (
    .clk_i   (MCLK_I),
    .rstn_i  (RSTN_I),
    .load_i  (act_load),
    .count_i (act_count),
    .busy_o  (act_busy)
  );

  dstc_gap_counter #(.W(CNT_W)) u_pre (
    .clk_i   (MCLK_I),
    .rstn_i  (RSTN_I),
    .load_i  (pre_load),
    .count_i (pre_count),
    .busy_o  (pre_busy)
  );

  always_ff @(posedge MCLK_I)
  begin
    if (!RSTN_I)
    begin
      memctl_r   <= MEMCTL_RESET;
      rdata_r    <= 32'h00000000;
      row_open_r <= 1'b0;
      init_mrs_r <= 1'b0;
      cas_neg_r  <= 6'h01;
      rcd_r      <= RCD_DRAM_BASE;
      act_hold_r <= 1'b0;
      pre_hold_r <= 1'b0;
    end
    else
    begin
      memctl_r   <= memctl_nxt;
      rdata_r    <= rdata_nxt;
      row_open_r <= memctl_r[ROW_OPEN_BIT];
      init_mrs_r <= memctl_r[INIT_CMD_BIT];
      cas_neg_r  <= cas_neg;
      rcd_r      <= rcd;
      act_hold_r <= act_load | act_busy;
      pre_hold_r <= pre_load | pre_busy;
    end
  end

  assign RDATA_O    = rdata_r;
  assign ROW_OPEN_O = row_open_r;
  assign INIT_MRS_O = init_mrs_r;
  assign CAS_NEG_O  = cas_neg_r;
  assign RCD_O      = rcd_r;
  assign ACT_HOLD_O = act_hold_r;
  assign PRE_HOLD_O = pre_hold_r;

  a_reset_clears: assert property (@(posedge MCLK_I)
    !RSTN_I |=> memctl_r == 32'h00000000)
    else $error("register not cleared by reset");

  a_reserved_zero: assert property (@(posedge MCLK_I)
    disable iff (!RSTN_I) (memctl_r & ~MEMCTL_WMASK) == 32'h0)
    else $error("reserved bits set");

  a_rowopen_follow: assert property (@(posedge MCLK_I)
    disable iff (!RSTN_I) ##1 ROW_OPEN_O == $past(memctl_r[31]))
    else $error("row open output wrong");

  a_initcmd_follow: assert property (@(posedge MCLK_I)
    disable iff (!RSTN_I) ##1 INIT_MRS_O == $past(memctl_r[30]))
    else $error("init command output wrong");

  a_cas_range: assert property (@(posedge MCLK_I)
    disable iff (!RSTN_I) ##1
    CAS_NEG_O == ($past(memctl_r[23]) ? 6'h02 : 6'h01))
    else $error("cas negation wrong");

  a_rcd_dram: assert property (@(posedge MCLK_I)
    disable iff (!RSTN_I) !SDRAM_SEL_I |-> rcd == memctl_r[17:16] + 6'h02)
    else $error("dram rcd wrong");

  a_write_hold: assert property (@(posedge MCLK_I)
    disable iff (!RSTN_I)
    (EVT_WR_I && SDRAM_SEL_I && !memctl_r[31] && !EVT_REF_I)
    |=> ACT_HOLD_O [*2])
    else $error("active not held after write");

  a_pre_hold: assert property (@(posedge MCLK_I)
    disable iff (!RSTN_I) (EVT_WR_I && SDRAM_SEL_I && memctl_r[31])
    |=> PRE_HOLD_O)
    else $error("precharge not held after write");

  a_wpd_dram_none: assert property (@(posedge MCLK_I)
    disable iff (!RSTN_I) !SDRAM_SEL_I |-> wpd == 6'h00)
    else $error("write delay used on dram");

  a_refr_end: assert property (@(posedge MCLK_I)
    disable iff (!RSTN_I) refr_end == 6'(memctl_r[29:27] * 3))
    else $error("refresh end precharge wrong");

  a_write_lands: assert property (@(posedge MCLK_I)
    disable iff (!RSTN_I) (WR_I && ADDR_I == MEMCTL_OFFSET)
    |=> memctl_r == ($past(WDATA_I) & MEMCTL_WMASK))
    else $error("register write not taken");

  a_memctl_kept: assert property (@(posedge MCLK_I)
    disable iff (!RSTN_I) !(WR_I && ADDR_I == MEMCTL_OFFSET)
    |=> $stable(memctl_r))
    else $error("register changed without write");

  a_read_value: assert property (@(posedge MCLK_I)
    disable iff (!RSTN_I) (RD_I && ADDR_I == MEMCTL_OFFSET)
    |=> RDATA_O == $past(memctl_r))
    else $error("read data wrong");

  a_read_reserved: assert property (@(posedge MCLK_I)
    disable iff (!RSTN_I) RD_I
    |=> (RDATA_O & ~MEMCTL_WMASK) == 32'h0)
    else $error("reserved bits read nonzero");

  a_rdata_idle: assert property (@(posedge MCLK_I)
    disable iff (!RSTN_I) !RD_I
    |=> RDATA_O == 32'h0)
    else $error("read data not cleared");

  a_dram_prech: assert property (@(posedge MCLK_I)
    disable iff (!RSTN_I) (EVT_PRE_I && !EVT_REF_I && !SDRAM_SEL_I)
    |-> act_count == {3'h0, memctl_r[21:19]})
    else $error("dram precharge count wrong");

  a_sdram_prech: assert property (@(posedge MCLK_I)
    disable iff (!RSTN_I)
    (EVT_PRE_I && SDRAM_SEL_I && !EVT_REF_I && !EVT_WR_I)
    |-> act_count == {3'h0, memctl_r[21:19]} + 6'h01)
    else $error("sdram precharge count wrong");

  a_sdram_rcd: assert property (@(posedge MCLK_I)
    disable iff (!RSTN_I) SDRAM_SEL_I
    |-> rcd == {4'h0, memctl_r[17:16]} + 6'h01)
    else $error("sdram rcd wrong");

  a_wpd_sdram: assert property (@(posedge MCLK_I)
    disable iff (!RSTN_I) SDRAM_SEL_I
    |-> wpd == {3'h0, memctl_r[15:13]} + 6'h01)
    else $error("write delay wrong");

  a_dram_refresh: assert property (@(posedge MCLK_I)
    disable iff (!RSTN_I) (EVT_REF_I && !SDRAM_SEL_I)
    |-> act_count == 6'(memctl_r[29:27] * 3))
    else $error("dram refresh count wrong");

  a_sdram_refresh: assert property (@(posedge MCLK_I)
    disable iff (!RSTN_I) (EVT_REF_I && SDRAM_SEL_I)
    |-> act_count == {3'h0, memctl_r[12:10]} + 6'h04
    + 6'(memctl_r[29:27] * 3))
    else $error("sdram refresh count wrong");

  a_auto_write: assert property (@(posedge MCLK_I)
    disable iff (!RSTN_I)
    (EVT_WR_I && SDRAM_SEL_I && !memctl_r[31] && !EVT_REF_I)
    |-> act_count == {3'h0, memctl_r[21:19]}
    + {3'h0, memctl_r[15:13]} + 6'h02)
    else $error("write hold count wrong");

  a_rowopen_write: assert property (@(posedge MCLK_I)
    disable iff (!RSTN_I) (EVT_WR_I && SDRAM_SEL_I && memctl_r[31])
    |-> pre_count == {3'h0, memctl_r[15:13]} + 6'h01)
    else $error("row open write count wrong");

  a_dram_no_pre: assert property (@(posedge MCLK_I)
    disable iff (!RSTN_I) !SDRAM_SEL_I
    |-> !pre_load)
    else $error("precharge hold started on dram");

  a_act_ignored: assert property (@(posedge MCLK_I)
    disable iff (!RSTN_I)
    (EVT_ACT_I && !EVT_REF_I && !EVT_WR_I && !EVT_PRE_I && !act_busy)
    |=> !ACT_HOLD_O)
    else $error("bank active started a hold");

  a_act_release: assert property (@(posedge MCLK_I)
    disable iff (!RSTN_I) (!act_load && !act_busy)
    |=> !ACT_HOLD_O)
    else $error("active hold not released");

  a_pre_release: assert property (@(posedge MCLK_I)
    disable iff (!RSTN_I) (!pre_load && !pre_busy)
    |=> !PRE_HOLD_O)
    else $error("precharge hold not released");
endmodule

// ### verification/dstc_mem_model.sv
`timescale 1ns/1ps
module dstc_mem_model #(
  parameter int DLY = 1  // answer delay in cycles
)(
  input  wire logic       clk_i,   // bus clock
  input  wire logic       go_i,    // start a command
  input  wire logic [1:0] kind_i,  // 0 act 1 wr 2 ref 3 pre
  output logic [3:0]      evt_o    // one-cycle done pulses
);
  int         cnt = -1;
  logic [1:0] k   = 2'h0;
  always @(posedge clk_i)
  begin
    evt_o <= 4'h0;
    if (go_i)
    begin
      cnt <= DLY;
      k   <= kind_i;
    end
    else if (cnt > 0)
      cnt <= cnt - 1;
    else if (cnt == 0)
    begin
      evt_o <= 4'h1 << k;
      cnt   <= -1;
    end
  end
endmodule

// ### verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  import dstc_pkg::*;
  localparam logic [31:0] RSV = 32'h07440000;
  logic        mclk = 0, rstn = 0, wr = 0, rd = 0, sdsel = 0, go = 0, rd_d = 0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic        row_open, init_mrs, act_hold, pre_hold;
  logic [5:0]  cas_neg, rcd;
  logic [1:0]  kind = 2'h0;
  logic [3:0]  evt;
  logic [31:0] q[$];
  int          n_fail = 0, tests_run = 0, cyc = 0;

  always #5 mclk = ~mclk;

  dstc_top uut (.MCLK_I(mclk), .RSTN_I(rstn), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .SDRAM_SEL_I(sdsel), .EVT_ACT_I(evt[0]),
    .EVT_WR_I(evt[1]), .EVT_REF_I(evt[2]), .EVT_PRE_I(evt[3]),
    .RDATA_O(rdata), .ROW_OPEN_O(row_open), .INIT_MRS_O(init_mrs),
    .CAS_NEG_O(cas_neg), .RCD_O(rcd), .ACT_HOLD_O(act_hold),
    .PRE_HOLD_O(pre_hold));
  dstc_mem_model #(.DLY(1)) mem (.clk_i(mclk), .go_i(go), .kind_i(kind),
    .evt_o(evt));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_fail++;
      tally_and_finish;
    end
  end

  // read data stands only in the cycle after the strobe
  always @(posedge mclk)
  begin
    if (rd_d && q.size() > 0)
      chk(rdata, q.pop_front());
    rd_d = rd;
  end

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    wr    <= w;
    rd    <= !w;
    addr  <= a;
    wdata <= d;
  endtask

  task automatic rdx(input logic [3:0] a, input logic [31:0] e);
    q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic idle;
    @(posedge mclk);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic cfg(input logic ro, mrs, cas, sd, input logic [2:0] trc, tpc,
                     input logic [1:0] rc, input logic [2:0] tw, tr);
    logic [31:0] v;
    v = {ro, mrs, trc, 3'h0, cas, 1'b0, tpc, 1'b0, rc, tw, tr, 10'h0};
    v = v | 32'(10'($urandom)) | {22'h0, ro, 9'h0};
    @(posedge mclk);
    sdsel <= sd;
    bus(1'b1, 4'h0, v);
    rdx(4'h0, v);
    idle;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk(row_open, ro);
    chk(init_mrs, mrs);
    chk(cas_neg, cas ? 6'h2 : 6'h1);
    chk(rcd, rc + (sd ? 6'h1 : 6'h2));
  endtask

  // hold length in cycles after one memory event
  task automatic hold(input logic [1:0] kd, input logic sel, input int n);
    int w;
    int len;
    w = 0;
    len = 0;
    @(posedge mclk);
    go   <= 1'b1;
    kind <= kd;
    @(posedge mclk);
    go <= 1'b0;
    while ((sel ? pre_hold : act_hold) !== 1'b1 && w < 12)
    begin
      @(negedge mclk);
      w++;
    end
    while ((sel ? pre_hold : act_hold) === 1'b1 && len < 80)
    begin
      @(negedge mclk);
      len++;
    end
    chk(len, n);
  endtask

  initial
  begin
    logic [2:0]  a, b, c, d;
    logic [1:0]  r;
    logic [31:0] v;
    void'($urandom(97206));
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    rdx(4'h0, 32'h0);
    v = $urandom;
    bus(1'b1, 4'h0, v);
    rdx(4'h0, v & ~RSV);
    bus(1'b1, 4'h8, ~v);
    rdx(4'h8, 32'h0);
    rdx(4'h0, v & ~RSV);
    rdx(4'h4, 32'h0);
    bus(1'b1, 4'h0, (v & ~RSV) ^ 32'h00000006);
    rdx(4'h0, (v & ~RSV) ^ 32'h00000006);
    idle;
    $display("test register access done");
    for (int i = 0; i < 6; i++)
    begin
      a = 3'($urandom);
      b = 3'($urandom);
      c = 3'($urandom % 5);
      d = 3'($urandom);
      r = 2'($urandom);
      cfg(1'b0, a[0], b[1], 1'b0, a, b, r, c, d);
      hold(2'h2, 1'b0, a * 3 + 1);
      hold(2'h1, 1'b0, 0);
      hold(2'h3, 1'b0, b + 1);
      cfg(1'b0, d[0], c[0], 1'b1, a, b, r | 2'h1, c, d);
      hold(2'h2, 1'b0, d + 4 + a * 3 + 1);
      hold(2'h1, 1'b0, b + c + 3);
      hold(2'h0, 1'b0, 0);
      hold(2'h3, 1'b0, b + 2);
      cfg(1'b1, 1'b0, 1'b0, 1'b1, a, b & 3'h3, 2'h1 + r[0], c, d);
      hold(2'h1, 1'b1, c + 2);
    end
    $display("test timing done");
    @(posedge mclk);
    rstn <= 1'b0;
    sdsel <= 1'b0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    rdx(4'h0, 32'h0);
    idle;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk(rcd, 6'h2);
    chk(row_open, 1'b0);
    $display("test second reset done");
    repeat (3) @(posedge mclk);
    tally_and_finish;
  end
endmodule
